// ### verilog/ieb_pkg.sv
// Package: register map, field positions and bus types for the enable/pending block
//Contract
//- Disable register bit n clears enable of interrupt 32+n (interrupts 32..63).
//- Writing one to a disable bit clears that enable; zero leaves it unchanged.
//- Reading the disable register returns current enable state, one meaning enabled.
//- Set-pending register bit n maps straight to interrupt n (interrupts 0..31).
//- Writing one to a set-pending bit makes that interrupt pending; zero does nothing.
//- A set-pending one is ignored when already pending or disabled.
//- Reading the set-pending register returns current pending state, one meaning pending.
//- Writing one to a clear-pending bit clears that interrupt's pending state.
//- Writing one to a set-enable bit enables the interrupt; zero has no effect.
package ieb_pkg;

	localparam int NUM_IRQ   = 64;
	localparam int HALF      = 32;
	localparam int ADDR_W    = 6;
	localparam int DATA_W    = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_EN_SET_LO   = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_EN_SET_HI   = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_EN_CLR_LO   = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_DISABLE_UP  = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_PEND_SET_LO = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_PEND_SET_HI = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_PEND_CLR_LO = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_PEND_CLR_HI = 6'h1C;
	localparam logic [ADDR_W-1:0] OFS_EVT_STATUS  = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_EVT_MASK    = 6'h24;

	// Event status fields
	localparam int EVT_W          = 2;
	localparam int EVT_SET_IGNORE = 0;
	localparam int EVT_NEW_PEND   = 1;

	// Values after reset
	localparam logic [NUM_IRQ-1:0] RST_ENABLE  = 64'h0000_0000_0000_0000;
	localparam logic [NUM_IRQ-1:0] RST_PENDING = 64'h0000_0000_0000_0000;
	localparam logic [EVT_W-1:0]   RST_EVT     = 2'h0;
	localparam logic [DATA_W-1:0]  RD_UNMAPPED = 32'h0000_0000;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} ieb_bus_t;

endpackage : ieb_pkg

// ### verilog/ieb_rst_sync.sv
// Two-flop release synchroniser for the active-low reset
`timescale 1ns/100ps
module ieb_rst_sync (
	input  wire logic mclk,
	input  wire logic nrst,
	output logic      rst_n
);
	import ieb_pkg::*;

	logic meta_q;
	logic hold_q;

	// Assert at once, release only after two edges
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			meta_q <= 1'b1;
			hold_q <= meta_q;
		end
	end

	assign rst_n = hold_q;

endmodule : ieb_rst_sync

// ### verilog/ieb_flag_bits.sv
// Vector of sticky flags; per bit a set beats a clear in the same cycle
`timescale 1ns/100ps
module ieb_flag_bits #(
	parameter int               WIDTH = 32,
	parameter logic [WIDTH-1:0] RST   = '0
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] set,
	input  wire logic [WIDTH-1:0] clr,
	output logic      [WIDTH-1:0] q
);
	import ieb_pkg::*;

	logic [WIDTH-1:0] flag_q;
	logic [WIDTH-1:0] flag_d;

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign flag_d[i] = set[i] | (flag_q[i] & ~clr[i]);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= RST;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign q = flag_q;

endmodule : ieb_flag_bits

// ### verilog/ieb_top.sv
// Enable and pending state for 64 interrupt sources with register port
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module ieb_top (
	// Clock and reset
	input  wire logic                         mclk,
	input  wire logic                         nrst,
	// Register port
	input  wire ieb_pkg::ieb_bus_t            bus,
	output logic      [ieb_pkg::DATA_W-1:0]   rdata,
	// Peripheral request lines
	input  wire logic [ieb_pkg::NUM_IRQ-1:0]  irq_req,
	// State toward priority logic
	output logic      [ieb_pkg::NUM_IRQ-1:0]  enable_state,
	output logic      [ieb_pkg::NUM_IRQ-1:0]  pending_state,
	// Event interrupt
	output logic                              irq
);
	import ieb_pkg::*;

	logic                 rst_n;
	logic [NUM_IRQ-1:0]   en_q;
	logic [NUM_IRQ-1:0]   pend_q;
	logic [EVT_W-1:0]     evt_q;
	logic [EVT_W-1:0]     mask_q;
	logic [EVT_W-1:0]     mask_d;
	logic [DATA_W-1:0]    rdata_q;
	logic [DATA_W-1:0]    rdata_d;

	ieb_rst_sync u_rst (
		.mclk  (mclk),
		.nrst  (nrst),
		.rst_n (rst_n)
	);

	// Address decode
	wire w_en_set_lo   = bus.wr && (bus.addr == OFS_EN_SET_LO);
	wire w_en_set_hi   = bus.wr && (bus.addr == OFS_EN_SET_HI);
	wire w_en_clr_lo   = bus.wr && (bus.addr == OFS_EN_CLR_LO);
	wire w_disable_up  = bus.wr && (bus.addr == OFS_DISABLE_UP);
	wire w_pend_set_lo = bus.wr && (bus.addr == OFS_PEND_SET_LO);
	wire w_pend_set_hi = bus.wr && (bus.addr == OFS_PEND_SET_HI);
	wire w_pend_clr_lo = bus.wr && (bus.addr == OFS_PEND_CLR_LO);
	wire w_pend_clr_hi = bus.wr && (bus.addr == OFS_PEND_CLR_HI);
	wire w_evt_status  = bus.wr && (bus.addr == OFS_EVT_STATUS);
	wire w_evt_mask    = bus.wr && (bus.addr == OFS_EVT_MASK);

	// Mapped words sit on a 4-byte grid from zero up to the mask register
	wire adr_mapped = (bus.addr <= OFS_EVT_MASK) && (bus.addr[1:0] == 2'h0);

	wire [DATA_W-1:0] wmask = bus.wdata;
	wire [DATA_W-1:0] zero  = '0;

	// Enable vector: set-enable writes and clear-enable writes
	wire [NUM_IRQ-1:0] en_set = {w_en_set_hi ? wmask : zero,
		w_en_set_lo ? wmask : zero};
	wire [NUM_IRQ-1:0] en_clr = {w_disable_up ? wmask : zero,
		w_en_clr_lo ? wmask : zero};

	ieb_flag_bits #(
		.WIDTH (NUM_IRQ),
		.RST   (RST_ENABLE)
	) u_enable (
		.mclk  (mclk),
		.rst_n (rst_n),
		.set   (en_set),
		.clr   (en_clr),
		.q     (en_q)
	);

	// Pending vector; a request or set only lands on an enabled line
	wire [NUM_IRQ-1:0] sw_pend = {w_pend_set_hi ? wmask : zero,
		w_pend_set_lo ? wmask : zero};
	wire [NUM_IRQ-1:0] pend_set = (sw_pend | irq_req) & en_q & ~pend_q;
	wire [NUM_IRQ-1:0] pend_clr = {w_pend_clr_hi ? wmask : zero,
		w_pend_clr_lo ? wmask : zero};

	// A clear beats the request of a pending line; a held request re-pends it next cycle
	ieb_flag_bits #(
		.WIDTH (NUM_IRQ),
		.RST   (RST_PENDING)
	) u_pending (
		.mclk  (mclk),
		.rst_n (rst_n),
		.set   (pend_set),
		.clr   (pend_clr),
		.q     (pend_q)
	);

	// Events: software set ignored on a disabled, not yet pending line, and any newly pending line
	wire ign_set = |(sw_pend & ~en_q & ~pend_q);
	wire new_pend = |pend_set;
	wire [EVT_W-1:0] evt_set = {new_pend, ign_set};
	wire [EVT_W-1:0] evt_clr = w_evt_status ? bus.wdata[EVT_W-1:0] : '0;

	ieb_flag_bits #(
		.WIDTH (EVT_W),
		.RST   (RST_EVT)
	) u_events (
		.mclk  (mclk),
		.rst_n (rst_n),
		.set   (evt_set),
		.clr   (evt_clr),
		.q     (evt_q)
	);

	assign mask_d = w_evt_mask ? bus.wdata[EVT_W-1:0] : mask_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= RST_EVT;
		end else begin
			mask_q <= mask_d;
		end
	end

	// Read mux; set and clear registers of a half both show its state
	wire [DATA_W-1:0] en_lo   = en_q[HALF-1:0];
	wire [DATA_W-1:0] en_hi   = en_q[NUM_IRQ-1:HALF];
	wire [DATA_W-1:0] pend_lo = pend_q[HALF-1:0];
	wire [DATA_W-1:0] pend_hi = pend_q[NUM_IRQ-1:HALF];

	always_comb begin
		unique case (bus.addr)
			OFS_EN_SET_LO, OFS_EN_CLR_LO: rdata_d = en_lo;
			OFS_EN_SET_HI, OFS_DISABLE_UP: rdata_d = en_hi;
			OFS_PEND_SET_LO, OFS_PEND_CLR_LO: rdata_d = pend_lo;
			OFS_PEND_SET_HI, OFS_PEND_CLR_HI: rdata_d = pend_hi;
			OFS_EVT_STATUS: rdata_d = {{(DATA_W-EVT_W){1'b0}}, evt_q};
			OFS_EVT_MASK: rdata_d = {{(DATA_W-EVT_W){1'b0}}, mask_q};
			default: rdata_d = RD_UNMAPPED;
		endcase
	end

	// Read data held only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= RD_UNMAPPED;
		end else begin
			rdata_q <= bus.rd ? rdata_d : RD_UNMAPPED;
		end
	end

	assign rdata         = rdata_q;
	assign enable_state  = en_q;
	assign pending_state = pend_q;
	assign irq           = |(evt_q & mask_q);

	// Checks beside the logic

	property p_dis_clears;
		@(posedge mclk) disable iff (!rst_n)
		w_disable_up |=> (en_q[NUM_IRQ-1:HALF] & $past(bus.wdata)) == '0;
	endproperty
	a_dis_clears: assert property (p_dis_clears)
		else $error("disable write left an enable set");

	property p_dis_keeps;
		@(posedge mclk) disable iff (!rst_n)
		w_disable_up |=> (en_q[NUM_IRQ-1:HALF] & ~$past(bus.wdata))
			== ($past(en_hi) & ~$past(bus.wdata));
	endproperty
	a_dis_keeps: assert property (p_dis_keeps)
		else $error("disable write disturbed a zero bit");

	property p_dis_read;
		@(posedge mclk) disable iff (!rst_n)
		(bus.rd && bus.addr == OFS_DISABLE_UP) |=> rdata == $past(en_hi);
	endproperty
	a_dis_read: assert property (p_dis_read)
		else $error("disable read not the enable state");

	property p_pend_set;
		@(posedge mclk) disable iff (!rst_n)
		w_pend_set_lo |=> (($past(bus.wdata) & $past(en_lo)) & ~pend_q[HALF-1:0]) == '0;
	endproperty
	a_pend_set: assert property (p_pend_set)
		else $error("set-pending write did not pend");

	property p_pend_ignore;
		@(posedge mclk) disable iff (!rst_n)
		w_pend_set_lo |=> (pend_q[HALF-1:0] & ~$past(pend_lo) & ~$past(en_lo)) == '0;
	endproperty
	a_pend_ignore: assert property (p_pend_ignore)
		else $error("disabled line became pending");

	property p_pend_read;
		@(posedge mclk) disable iff (!rst_n)
		(bus.rd && bus.addr == OFS_PEND_SET_LO) |=> rdata == $past(pend_lo);
	endproperty
	a_pend_read: assert property (p_pend_read)
		else $error("set-pending read not the pending state");

	property p_pend_clr;
		@(posedge mclk) disable iff (!rst_n)
		w_pend_clr_lo |=>
			(pend_q[HALF-1:0] & $past(bus.wdata) & ~$past(irq_req[HALF-1:0])) == '0;
	endproperty
	a_pend_clr: assert property (p_pend_clr)
		else $error("clear-pending write left a line pending");

	property p_en_set;
		@(posedge mclk) disable iff (!rst_n)
		w_en_set_hi |=> ($past(bus.wdata) & ~en_q[NUM_IRQ-1:HALF]) == '0;
	endproperty
	a_en_set: assert property (p_en_set)
		else $error("set-enable write did not enable");

	property p_wr_then_rd;
		@(posedge mclk) disable iff (!rst_n)
		(w_disable_up ##1 (bus.rd && bus.addr == OFS_DISABLE_UP))
			|=> (rdata & $past(bus.wdata, 2)) == '0;
	endproperty
	a_wr_then_rd: assert property (p_wr_then_rd)
		else $error("read after disable shows stale enable");

	property p_rd_idle;
		@(posedge mclk) disable iff (!rst_n)
		!bus.rd |=> rdata == RD_UNMAPPED;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside the answer cycle");

	property p_clr_lo_clears;
		@(posedge mclk) disable iff (!rst_n)
		w_en_clr_lo |=> (en_q[HALF-1:0] & $past(bus.wdata)) == '0;
	endproperty
	a_clr_lo_clears: assert property (p_clr_lo_clears)
		else $error("clear-enable write left an enable set");

	property p_en_set_lo;
		@(posedge mclk) disable iff (!rst_n)
		w_en_set_lo |=> ($past(bus.wdata) & ~en_q[HALF-1:0]) == '0;
	endproperty
	a_en_set_lo: assert property (p_en_set_lo)
		else $error("set-enable write did not enable a low line");

	property p_en_set_keeps;
		@(posedge mclk) disable iff (!rst_n)
		w_en_set_hi |=> (en_q[NUM_IRQ-1:HALF] & ~$past(bus.wdata))
			== ($past(en_hi) & ~$past(bus.wdata));
	endproperty
	a_en_set_keeps: assert property (p_en_set_keeps)
		else $error("set-enable write disturbed a zero bit");

	property p_en_steady;
		@(posedge mclk) disable iff (!rst_n)
		!(w_en_set_lo || w_en_set_hi || w_en_clr_lo || w_disable_up)
			|=> en_q == $past(en_q);
	endproperty
	a_en_steady: assert property (p_en_steady)
		else $error("enable changed without an enable write");

	property p_dis_up_only;
		@(posedge mclk) disable iff (!rst_n)
		w_disable_up |=> en_q[HALF-1:0] == $past(en_lo);
	endproperty
	a_dis_up_only: assert property (p_dis_up_only)
		else $error("disable write touched a low line");

	property p_pend_set_hi;
		@(posedge mclk) disable iff (!rst_n)
		w_pend_set_hi |=> (($past(bus.wdata) & $past(en_hi)) & ~pend_q[NUM_IRQ-1:HALF]) == '0;
	endproperty
	a_pend_set_hi: assert property (p_pend_set_hi)
		else $error("upper set-pending write did not pend");

	property p_pend_ign_hi;
		@(posedge mclk) disable iff (!rst_n)
		w_pend_set_hi |=> (pend_q[NUM_IRQ-1:HALF] & ~$past(pend_hi) & ~$past(en_hi)) == '0;
	endproperty
	a_pend_ign_hi: assert property (p_pend_ign_hi)
		else $error("disabled upper line became pending");

	property p_pend_map;
		@(posedge mclk) disable iff (!rst_n)
		w_pend_set_lo |=> (pend_q[NUM_IRQ-1:HALF] & ~$past(pend_hi)
			& ~$past(irq_req[NUM_IRQ-1:HALF])) == '0;
	endproperty
	a_pend_map: assert property (p_pend_map)
		else $error("low set-pending write pended an upper line");

	property p_pend_gated;
		@(posedge mclk) disable iff (!rst_n)
		rst_n |=> (pend_q & ~$past(pend_q) & ~$past(en_q)) == '0;
	endproperty
	a_pend_gated: assert property (p_pend_gated)
		else $error("a disabled line became pending");

	property p_req_pends;
		@(posedge mclk) disable iff (!rst_n)
		rst_n |=>
			($past(irq_req) & $past(en_q) & ~$past(pend_q) & ~pend_q) == '0;
	endproperty
	a_req_pends: assert property (p_req_pends)
		else $error("enabled request did not pend");

	property p_pend_clr_hi;
		@(posedge mclk) disable iff (!rst_n)
		w_pend_clr_hi |=> (pend_q[NUM_IRQ-1:HALF] & $past(bus.wdata)
			& ~$past(irq_req[NUM_IRQ-1:HALF])) == '0;
	endproperty
	a_pend_clr_hi: assert property (p_pend_clr_hi)
		else $error("upper clear-pending write left a line pending");

	property p_pend_clr_keeps;
		@(posedge mclk) disable iff (!rst_n)
		w_pend_clr_lo |=> ($past(pend_lo) & ~$past(bus.wdata) & ~pend_q[HALF-1:0]) == '0;
	endproperty
	a_pend_clr_keeps: assert property (p_pend_clr_keeps)
		else $error("clear-pending write dropped a zero bit");

	property p_pend_rd_hi;
		@(posedge mclk) disable iff (!rst_n)
		(bus.rd && (bus.addr == OFS_PEND_SET_HI || bus.addr == OFS_PEND_CLR_HI))
			|=> rdata == $past(pend_hi);
	endproperty
	a_pend_rd_hi: assert property (p_pend_rd_hi)
		else $error("upper pending read not the pending state");

	property p_pend_wr_rd;
		@(posedge mclk) disable iff (!rst_n)
		(w_pend_set_lo ##1 (bus.rd && bus.addr == OFS_PEND_SET_LO))
			|=> (~rdata & $past(bus.wdata, 2) & $past(en_lo, 2)) == '0;
	endproperty
	a_pend_wr_rd: assert property (p_pend_wr_rd)
		else $error("read after set-pending shows stale state");

	property p_evt_ignored;
		@(posedge mclk) disable iff (!rst_n)
		(w_pend_set_lo && |(bus.wdata & ~en_lo & ~pend_lo)) |=> evt_q[EVT_SET_IGNORE];
	endproperty
	a_evt_ignored: assert property (p_evt_ignored)
		else $error("ignored set-pending not flagged");

	property p_evt_new;
		@(posedge mclk) disable iff (!rst_n)
		((pend_q & ~$past(pend_q)) != '0) |-> evt_q[EVT_NEW_PEND];
	endproperty
	a_evt_new: assert property (p_evt_new)
		else $error("new pending line not flagged");

	property p_mask_wr;
		@(posedge mclk) disable iff (!rst_n)
		w_evt_mask |=> mask_q == $past(bus.wdata[EVT_W-1:0]);
	endproperty
	a_mask_wr: assert property (p_mask_wr)
		else $error("mask write did not land");

	property p_rd_unmapped;
		@(posedge mclk) disable iff (!rst_n)
		(bus.rd && !adr_mapped) |=> rdata == RD_UNMAPPED;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped read returned data");

endmodule : ieb_top

// ### tb/ieb_req_model.sv
// Peripheral request source: level lines held until dropped
`timescale 1ns/100ps
module ieb_req_model (
	// Clock
	input  wire logic        mclk,
	// Control from the bench
	input  wire logic [63:0] raise,
	input  wire logic [63:0] drop,
	// Request lines
	output logic      [63:0] irq_req
);
	// Known level from time zero so no stray request lands
	initial irq_req = 64'h0;
	// Lines move just after an edge, like a real peripheral
	always @(posedge mclk) begin
		irq_req <= (irq_req | raise) & ~drop;
	end
endmodule : ieb_req_model

// ### tb/ieb_top_bench.sv
// Self-checking bench for the enable and pending block
`timescale 1ns/100ps
module ieb_top_bench;
	import ieb_pkg::*;
	typedef struct packed {
		logic              w;
		logic [ADDR_W-1:0] a;
		logic [31:0]       d;
		logic [31:0]       e;
	} ieb_row_t;
	localparam logic        WR = 1'b1;
	localparam logic        RD = 1'b0;
	localparam logic [31:0] Z  = 32'h0000_0000;
	logic        mclk  = 1'b0;
	logic        nrst  = 1'b0;
	ieb_bus_t    bus   = '0;
	logic [31:0] rdata;
	logic [31:0] exp_n = Z;
	logic [31:0] exp_s = Z;
	logic        rd_s  = 1'b0;
	logic        irq;
	logic [63:0] irq_req;
	logic [63:0] en_st;
	logic [63:0] pd_st;
	logic [63:0] raise = 64'h0;
	logic [63:0] drop  = 64'h0;
	int          n_fail = 0;
	int          total_checks = 0;
	int          cyc = 0;
	// Back to back: each row follows the one before it with no gap
	ieb_row_t    rows [23] = '{
		'{WR, OFS_EN_SET_HI, 32'hFFFF_FFFF, Z},
		'{RD, OFS_DISABLE_UP, Z, 32'hFFFF_FFFF},
		'{WR, OFS_DISABLE_UP, 32'h0000_0001, Z},
		'{RD, OFS_DISABLE_UP, Z, 32'hFFFF_FFFE},
		'{WR, OFS_DISABLE_UP, Z, Z},
		'{WR, OFS_DISABLE_UP, 32'h8000_0000, Z},
		'{RD, OFS_DISABLE_UP, Z, 32'h7FFF_FFFE},
		'{WR, OFS_EN_SET_LO, 32'h0000_00FF, Z},
		'{WR, OFS_PEND_SET_LO, 32'h0000_0F0F, Z},
		'{RD, OFS_PEND_SET_LO, Z, 32'h0000_000F},
		'{WR, OFS_PEND_CLR_LO, 32'h0000_0001, Z},
		'{RD, OFS_PEND_SET_LO, Z, 32'h0000_000E},
		'{WR, OFS_PEND_SET_LO, 32'h0000_0003, Z},
		'{RD, OFS_PEND_SET_LO, Z, 32'h0000_000F},
		'{WR, OFS_EN_CLR_LO, 32'h0000_0080, Z},
		'{RD, OFS_EN_CLR_LO, Z, 32'h0000_007F},
		'{WR, OFS_PEND_SET_HI, 32'h0000_0200, Z},
		'{RD, OFS_PEND_SET_HI, Z, 32'h0000_0200},
		'{RD, OFS_PEND_CLR_HI, Z, 32'h0000_0200},
		'{RD, OFS_EVT_STATUS, Z, 32'h0000_0003},
		'{WR, 6'h3C, 32'hFFFF_FFFF, Z},
		'{RD, 6'h3C, Z, Z},
		'{RD, OFS_DISABLE_UP, Z, 32'h7FFF_FFFE}
	};

	ieb_top dut (.mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata), .irq_req(irq_req),
		.enable_state(en_st), .pending_state(pd_st), .irq(irq));
	ieb_req_model peri (.mclk(mclk), .raise(raise), .drop(drop), .irq_req(irq_req));

	always #2.5 mclk = ~mclk;

	task check(input logic [63:0] s, input logic [63:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	endtask : check

	task test_done;
		if (n_fail == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	// Called at an edge; leaves the strobe up so the next op can follow at once
	task op(input ieb_row_t r);
		bus   <= '{r.a, r.d, r.w, !r.w};
		exp_n <= r.e;
		@(posedge mclk);
	endtask : op

	task wait_n(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wait_n

	task idle(input int n);
		bus.wr <= 1'b0;
		bus.rd <= 1'b0;
		wait_n(n);
	endtask : idle

	// Read data only in the cycle after the strobe, zero elsewhere
	always @(posedge mclk) begin
		rd_s  <= bus.rd;
		exp_s <= exp_n;
		cyc   <= cyc + 1;
		if (cyc > 2000) begin
			n_fail++;
			test_done();
		end
	end
	always @(negedge mclk) check(rdata, rd_s ? exp_s : Z);

	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		wait_n(3);
		check(en_st, RST_ENABLE);
		check(pd_st, RST_PENDING);
		check(irq, 1'b0);
		@(posedge mclk);
		foreach (rows[i]) op(rows[i]);
		idle(1);
		check(irq, 1'b0);
		@(posedge mclk);
		op('{WR, OFS_EVT_MASK, 32'h0000_0002, Z});
		op('{RD, OFS_EVT_MASK, Z, 32'h0000_0002});
		idle(2);
		check(irq, 1'b1);
		@(posedge mclk);
		op('{WR, OFS_EVT_STATUS, 32'h0000_0003, Z});
		op('{RD, OFS_EVT_STATUS, Z, Z});
		idle(2);
		check(irq, 1'b0);
		// Line 32 is disabled, line 40 enabled
		@(posedge mclk);
		raise <= 64'h0000_0101_0000_0000;
		@(posedge mclk);
		raise <= 64'h0;
		wait_n(2);
		check(pd_st[40], 1'b1);
		check(pd_st[32], 1'b0);
		check(irq, 1'b1);
		// Clear with request still high: the clear lands, then the held request re-pends the line
		@(posedge mclk);
		op('{WR, OFS_PEND_CLR_HI, 32'h0000_0100, Z});
		idle(1);
		check(pd_st[40], 1'b1);
		@(posedge mclk);
		drop <= 64'h0000_0100_0000_0000;
		@(posedge mclk);
		drop <= 64'h0;
		op('{WR, OFS_PEND_CLR_HI, 32'h0000_0100, Z});
		idle(1);
		check(pd_st[40], 1'b0);
		// Second reset in mid-run
		@(posedge mclk);
		nrst <= 1'b0;
		wait_n(1);
		check(en_st, RST_ENABLE);
		check(pd_st, RST_PENDING);
		check(irq, 1'b0);
		@(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		op('{WR, OFS_EN_SET_LO, 32'h0000_0001, Z});
		op('{RD, OFS_EN_SET_LO, Z, 32'h0000_0001});
		idle(2);
		check(en_st[0], 1'b1);
		test_done();
	end
endmodule : ieb_top_bench
